// ==== verilog/itas_top.sv ====
// Purpose: global timing, energy select, alarms, general output and aux sync pulses
// Assumes: crank and speed inputs come synchronous from pickup synchronisation
// Notes:   Avalon-MM slave answers every access with exactly one wait cycle
// Function
// - analog input below failure threshold shifts timing by its error value.
// - error offset stays until the analog signal exceeds the lower limit.
// - per-cylinder offsets are clamped to the configured maximum from any source.
// - enabled speed curve offsets timing with up to eight points, first at zero.
// - start phase ends when every nonzero speed/time criterion is exceeded.
// - after start phase, normal energy parameters replace start energy parameters.
// - energy limit too low shortens spark duration only.
// - timing change per firing limited to configured step in both directions.
// - sixteen alarms with source, threshold, hysteresis, delay, output routing.
// - alarm triggers only after its condition outlasts the delay.
// - shutdown-enabled alarm switches ignition off and raises operational error.
// - permanent alarm keeps output until acknowledged, else follows alarm.
// - general output selectable normally closed or open, driven by routed alarms.
// - aux sync output makes one to sixteen pulses per engine cycle.
// - each pulse has own angle and microsecond length, absolute or timing-shifted.
// - pulse lengths above 300 microseconds are rejected.
// - default polarity is low-active, inverted polarity high-active.
// - active pulse edge coincides with configured crank angle.
// - timing-shifted reference emits pulses only while firing is active.
// - absolute reference emits pulses once pickups are synchronised.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module itas_top (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [8:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	input  wire logic         sync_ok,
	input  wire logic         firing_active,
	input  wire logic [15:0]  crank_angle,
	input  wire logic         angle_step,
	input  wire logic         fire_strobe,
	input  wire logic [15:0]  engine_speed,
	input  wire logic [31:0]  analog_in,
	input  wire logic [15:0]  pot_offset,
	input  wire logic [127:0] mon_values,
	input  wire logic         cyl_req_valid,
	input  wire logic [15:0]  cyl_req,
	output logic [15:0]       cyl_out,
	output logic [15:0]       timing_target,
	output logic [15:0]       timing_out,
	output logic [15:0]       spark_dur,
	output logic [7:0]        spark_int,
	output logic [7:0]        spark_bdv,
	output logic              start_phase,
	output logic              op_error,
	output logic              ignition_off,
	output logic              general_output_one,
	output logic              aux_sync_output_one
);
	logic [31:0] ctrl, base, lim, step, start_cfg, en_s, en_n, elim;
	logic [31:0] an_cfg [2*itas_pkg::N_AN];
	logic [31:0] curve [itas_pkg::N_CURVE];
	logic [31:0] aso [itas_pkg::N_ASO];
	logic [31:0] alcfg [2*itas_pkg::N_ALARM];
	logic        resp;
	logic        acc;
	logic        wr_go;
	logic        ack;
	logic [31:0] rd_mux;
	logic [31:0] wnew;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = be[b] ? w[8*b +: 8] : o[8*b +: 8];
	endfunction

	// bus slave: one wait cycle, write and read data at the edge waitrequest is low
	assign acc = avs_read | avs_write;
	assign avs_waitrequest = acc & ~resp;
	assign wr_go = avs_write & resp;
	assign ack = wr_go && avs_address == itas_pkg::A_ACK && avs_writedata[0];
	assign wnew = merge(rd_mux, avs_writedata, avs_byteenable);

	always_ff @(posedge clk) begin
		if (srst)
			resp <= 1'b0;
		else
			resp <= acc & ~resp;
	end

	always_ff @(posedge clk) begin
		if (srst)
			avs_readdata <= 32'h0;
		else if (acc && !resp)
			avs_readdata <= rd_mux;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl <= itas_pkg::CTRL_RST;
			base <= itas_pkg::ZERO_RST;
			lim <= itas_pkg::LIM_RST;
			step <= itas_pkg::STEP_RST;
			start_cfg <= itas_pkg::ZERO_RST;
			en_s <= itas_pkg::ZERO_RST;
			en_n <= itas_pkg::ZERO_RST;
			elim <= itas_pkg::ZERO_RST;
			for (int i = 0; i < 2*itas_pkg::N_AN; i++)
				an_cfg[i] <= itas_pkg::ZERO_RST;
			for (int i = 0; i < itas_pkg::N_CURVE; i++)
				curve[i] <= itas_pkg::ZERO_RST;
			for (int i = 0; i < itas_pkg::N_ASO; i++)
				aso[i] <= itas_pkg::ZERO_RST;
			for (int i = 0; i < 2*itas_pkg::N_ALARM; i++)
				alcfg[i] <= itas_pkg::ZERO_RST;
		end else if (wr_go) begin
			if (avs_address == itas_pkg::A_CTRL)
				ctrl <= wnew;
			if (avs_address == itas_pkg::A_BASE)
				base <= wnew;
			if (avs_address == itas_pkg::A_LIM)
				lim <= wnew;
			if (avs_address == itas_pkg::A_STEP)
				step <= wnew;
			if (avs_address == itas_pkg::A_START)
				start_cfg <= wnew;
			if (avs_address == itas_pkg::A_EN_S)
				en_s <= wnew;
			if (avs_address == itas_pkg::A_EN_N)
				en_n <= wnew;
			if (avs_address == itas_pkg::A_ELIM)
				elim <= wnew;
			if (avs_address >= itas_pkg::A_AN && avs_address < itas_pkg::A_CURVE)
				an_cfg[avs_address[3:2]] <= wnew;
			if (avs_address >= itas_pkg::A_CURVE && avs_address < itas_pkg::A_ASO)
				curve[avs_address[4:2]] <= wnew;
			// an over-long pulse length drops the whole write
			if (avs_address >= itas_pkg::A_ASO && avs_address < itas_pkg::A_ALARM &&
				wnew[24:16] <= 9'(itas_pkg::ASO_MAX_US))
				aso[avs_address[5:2]] <= wnew;
			if (avs_address >= itas_pkg::A_ALARM && avs_address < itas_pkg::A_START)
				alcfg[avs_address[6:2]] <= wnew;
		end
	end

	// time bases
	logic [6:0]  us_div;
	logic [9:0]  ms_div;
	logic        tick_us;
	logic        tick_ms;
	assign tick_us = us_div == 7'(itas_pkg::US_CYC - 1);
	assign tick_ms = tick_us && ms_div == 10'(itas_pkg::MS_US - 1);

	always_ff @(posedge clk) begin
		if (srst || tick_us)
			us_div <= 7'h0;
		else
			us_div <= us_div + 7'h1;
	end

	always_ff @(posedge clk) begin
		if (srst || tick_ms)
			ms_div <= 10'h0;
		else if (tick_us)
			ms_div <= ms_div + 10'h1;
	end

	// analog adjustment with failure handling
	localparam int N_AN_W = itas_pkg::N_AN;
	logic [N_AN_W-1:0] an_err;
	logic signed [15:0] an_adj [itas_pkg::N_AN];
	for (genvar c = 0; c < itas_pkg::N_AN; c++) begin : g_an
		logic [15:0]        val;
		logic signed [25:0] prod;
		assign val = analog_in[16*c +: 16];
		assign prod = $signed({1'b0, val} - {1'b0, an_cfg[2*c][15:0]}) *
			$signed({1'b0, an_cfg[2*c+1][23:16]});
		always_ff @(posedge clk) begin
			if (srst || !ctrl[itas_pkg::C_AN + c])
				an_err[c] <= 1'b0;
			else if (val < an_cfg[2*c][31:16])
				an_err[c] <= 1'b1;
			else if (val > an_cfg[2*c][15:0])
				an_err[c] <= 1'b0;
		end
		assign an_adj[c] = !ctrl[itas_pkg::C_AN + c] ? 16'sh0 :
			an_err[c] ? $signed(an_cfg[2*c+1][15:0]) : 16'(prod >>> 8);
	end

	// speed curve: the highest point reached sets the offset
	logic signed [15:0] curve_off;
	always_comb begin
		curve_off = 16'sh0;
		if (ctrl[itas_pkg::C_CURVE])
			for (int i = 0; i < itas_pkg::N_CURVE; i++)
				if (3'(i) <= ctrl[itas_pkg::C_NCURV +: 3] &&
					(i == 0 || engine_speed >= curve[i][15:0]))
					curve_off = $signed(curve[i][31:16]);
	end

	logic signed [18:0] sum;
	logic signed [18:0] lo;
	logic signed [18:0] hi;
	logic signed [15:0] next_target;
	assign lo = 19'($signed(lim[15:0]));
	assign hi = 19'($signed(lim[31:16]));
	assign sum = 19'($signed(base[15:0])) + 19'(an_adj[0]) + 19'(an_adj[1]) +
		19'(curve_off) + (ctrl[itas_pkg::C_POT] ? 19'($signed(pot_offset)) : 19'sh0);
	assign next_target = sum < lo ? lim[15:0] : sum > hi ? lim[31:16] : 16'(sum);

	always_ff @(posedge clk) begin
		if (srst)
			timing_target <= 16'h0;
		else
			timing_target <= next_target;
	end

	// the rate limit only moves at a firing
	logic signed [16:0] diff;
	logic signed [16:0] smax;
	assign diff = $signed({timing_target[15], timing_target}) -
		$signed({timing_out[15], timing_out});
	assign smax = $signed({2'b00, step[14:0]});

	always_ff @(posedge clk) begin
		if (srst)
			timing_out <= 16'h0;
		else if (fire_strobe) begin
			if (diff > smax)
				timing_out <= timing_out + {1'b0, step[14:0]};
			else if (diff < -smax)
				timing_out <= timing_out - {1'b0, step[14:0]};
			else
				timing_out <= timing_target;
		end
	end

	logic signed [15:0] cmax;
	assign cmax = $signed({1'b0, step[30:16]});

	always_ff @(posedge clk) begin
		if (srst)
			cyl_out <= 16'h0;
		else if (cyl_req_valid) begin
			if ($signed(cyl_req) > cmax)
				cyl_out <= cmax;
			else if ($signed(cyl_req) < -cmax)
				cyl_out <= -cmax;
			else
				cyl_out <= cyl_req;
		end
	end

	// start phase, restarted whenever synchronisation is lost
	itas_pkg::itas_phase_e phase;
	logic [15:0] run_ms;
	logic        end_ok;
	assign end_ok = (start_cfg[15:0] == 16'h0 || engine_speed > start_cfg[15:0]) &&
		(start_cfg[31:16] == 16'h0 || run_ms > start_cfg[31:16]);

	always_ff @(posedge clk) begin
		if (srst || !sync_ok)
			run_ms <= 16'h0;
		else if (tick_ms && run_ms != 16'hffff)
			run_ms <= run_ms + 16'h1;
	end

	always_ff @(posedge clk) begin
		if (srst || !sync_ok)
			phase <= itas_pkg::PH_IDLE;
		else
			unique case (phase)
			itas_pkg::PH_IDLE:
				phase <= itas_pkg::PH_START;
			itas_pkg::PH_START:
				if (end_ok)
					phase <= itas_pkg::PH_NORM;
			itas_pkg::PH_NORM:
				phase <= itas_pkg::PH_NORM;
			default:
				phase <= itas_pkg::PH_IDLE;
			endcase
	end
	assign start_phase = phase != itas_pkg::PH_NORM;

	// energy: only the duration gives way to the limit
	logic [31:0] en_sel;
	logic [23:0] need;
	logic [23:0] capd;
	assign en_sel = start_phase ? en_s : en_n;
	assign need = en_sel[15:0] * en_sel[23:16];
	assign capd = en_sel[23:16] == 8'h0 ? 24'h0 : elim[23:0] / {16'h0, en_sel[23:16]};

	always_ff @(posedge clk) begin
		if (srst) begin
			spark_dur <= 16'h0;
			spark_int <= 8'h0;
			spark_bdv <= 8'h0;
		end else begin
			spark_int <= en_sel[23:16];
			spark_bdv <= en_sel[31:24];
			if (en_sel[23:16] != 8'h0 && need > elim[23:0])
				spark_dur <= capd[15:0];
			else
				spark_dur <= en_sel[15:0];
		end
	end

	// alarms
	logic [itas_pkg::N_ALARM-1:0] al_act;
	logic [itas_pkg::N_ALARM-1:0] al_lat;
	logic [itas_pkg::N_ALARM-1:0] al_shut;
	logic [itas_pkg::N_ALARM-1:0] al_out;
	for (genvar a = 0; a < itas_pkg::N_ALARM; a++) begin : g_al
		logic [31:0] w1;
		assign w1 = alcfg[2*a+1];
		itas_alarm u_alarm (
			.clk     (clk),
			.srst    (srst),
			.tick_us (tick_us),
			.value   (mon_values[16*w1[itas_pkg::AL_SRC +: 3] +: 16]),
			.thr     (alcfg[2*a][15:0]),
			.hyst    (alcfg[2*a][31:16]),
			.delay   (w1[15:0]),
			.below   (w1[itas_pkg::AL_BELOW]),
			.ack     (ack),
			.active  (al_act[a]),
			.latched (al_lat[a])
		);
		assign al_shut[a] = al_act[a] & w1[itas_pkg::AL_SHUT];
		assign al_out[a] = w1[itas_pkg::AL_ROUTE] &
			(w1[itas_pkg::AL_PERM] ? al_lat[a] : al_act[a]);
	end

	// a new shutdown beats an acknowledge in the same cycle
	always_ff @(posedge clk) begin
		if (srst)
			op_error <= 1'b0;
		else if (|al_shut)
			op_error <= 1'b1;
		else if (ack)
			op_error <= 1'b0;
	end
	assign ignition_off = op_error | (|al_shut);
	assign general_output_one = ctrl[itas_pkg::C_GPO_NC] ^ (|al_out);

	// aux sync pulses
	logic [itas_pkg::N_ASO-1:0] hit;
	logic                       aso_en;
	logic [8:0]                 aso_cnt;
	logic [8:0]                 next_len;
	assign aso_en = ctrl[itas_pkg::C_ASO_GT] ? firing_active : sync_ok;
	for (genvar p = 0; p < itas_pkg::N_ASO; p++) begin : g_aso
		logic [15:0] ref_ang;
		assign ref_ang = ctrl[itas_pkg::C_ASO_GT] ? aso[p][15:0] - timing_out :
			aso[p][15:0];
		assign hit[p] = angle_step && 4'(p) <= ctrl[itas_pkg::C_NPTS +: 4] &&
			crank_angle == ref_ang;
	end

	always_comb begin
		next_len = 9'h0;
		for (int p = itas_pkg::N_ASO - 1; p >= 0; p--)
			if (hit[p])
				next_len = aso[p][24:16];
	end

	// a pulse starts on the match edge; a match during a pulse restarts it
	always_ff @(posedge clk) begin
		if (srst)
			aso_cnt <= 9'h0;
		else if (aso_en && |hit)
			aso_cnt <= next_len;
		else if (tick_us && aso_cnt != 9'h0)
			aso_cnt <= aso_cnt - 9'h1;
	end
	assign aux_sync_output_one = ctrl[itas_pkg::C_ASO_INV] ~^ (aso_cnt != 9'h0);

	always_comb begin
		rd_mux = 32'h0;
		if (avs_address == itas_pkg::A_CTRL)
			rd_mux = ctrl;
		if (avs_address == itas_pkg::A_BASE)
			rd_mux = base;
		if (avs_address == itas_pkg::A_LIM)
			rd_mux = lim;
		if (avs_address == itas_pkg::A_STEP)
			rd_mux = step;
		if (avs_address == itas_pkg::A_START)
			rd_mux = start_cfg;
		if (avs_address == itas_pkg::A_EN_S)
			rd_mux = en_s;
		if (avs_address == itas_pkg::A_EN_N)
			rd_mux = en_n;
		if (avs_address == itas_pkg::A_ELIM)
			rd_mux = elim;
		if (avs_address == itas_pkg::A_STAT)
			rd_mux = {12'h0, an_err, op_error, start_phase, al_act};
		if (avs_address == itas_pkg::A_TIMING)
			rd_mux = {timing_target, timing_out};
		if (avs_address >= itas_pkg::A_AN && avs_address < itas_pkg::A_CURVE)
			rd_mux = an_cfg[avs_address[3:2]];
		if (avs_address >= itas_pkg::A_CURVE && avs_address < itas_pkg::A_ASO)
			rd_mux = curve[avs_address[4:2]];
		if (avs_address >= itas_pkg::A_ASO && avs_address < itas_pkg::A_ALARM)
			rd_mux = aso[avs_address[5:2]];
		if (avs_address >= itas_pkg::A_ALARM && avs_address < itas_pkg::A_START)
			rd_mux = alcfg[avs_address[6:2]];
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_err_hold: assert property (an_err[0] && !(analog_in[15:0] > an_cfg[0][15:0]) &&
		ctrl[itas_pkg::C_AN] |=> an_err[0])
		else $error("analog error offset dropped early");
	a_err_offset: assert property (an_err[0] && ctrl[itas_pkg::C_AN] |->
		an_adj[0] == $signed(an_cfg[1][15:0]))
		else $error("analog error value not applied");
	a_target_clamp: assert property (##1 $signed(timing_target) >= $signed($past(lim[15:0])) ||
		$signed($past(lim[15:0])) > $signed($past(lim[31:16])))
		else $error("global timing below lower limit");
	a_cyl_clamp: assert property (cyl_req_valid |=> $signed(cyl_out) <= $past(cmax))
		else $error("cylinder offset beyond limit");
	a_step_rate: assert property (!fire_strobe |=> timing_out == $past(timing_out))
		else $error("timing moved without a firing");
	a_step_size: assert property (fire_strobe && diff > smax |=>
		timing_out == $past(timing_out) + {1'b0, $past(step[14:0])})
		else $error("timing step not limited");
	a_start_end: assert property (phase == itas_pkg::PH_START && end_ok && sync_ok |=>
		phase == itas_pkg::PH_NORM)
		else $error("start phase did not end");
	a_energy_norm: assert property (phase == itas_pkg::PH_NORM ##1 phase == itas_pkg::PH_NORM
		|-> spark_int == $past(en_n[23:16]))
		else $error("normal energy not in use");
	a_shutdown: assert property (|al_shut |-> ignition_off ##1 op_error)
		else $error("shutdown alarm did not stop ignition");
	a_aso_reject: assert property (wr_go && avs_address >= itas_pkg::A_ASO &&
		avs_address < itas_pkg::A_ALARM && wnew[24:16] > 9'(itas_pkg::ASO_MAX_US) |=>
		aso[$past(avs_address[5:2])] == $past(aso[avs_address[5:2]]))
		else $error("over-long aux pulse accepted");
	a_aso_gate: assert property ($rose(aso_cnt != 9'h0) |-> $past(aso_en))
		else $error("aux pulse while not released");
	a_gpo_perm: assert property (al_lat[0] && alcfg[1][itas_pkg::AL_PERM] &&
		alcfg[1][itas_pkg::AL_ROUTE] |-> general_output_one != ctrl[itas_pkg::C_GPO_NC])
		else $error("permanent alarm output released");
	c_aso_pulse: cover property ($rose(aso_cnt != 9'h0));
	c_start_done: cover property (phase == itas_pkg::PH_START ##1 phase == itas_pkg::PH_NORM);
	c_shutdown: cover property ($rose(op_error));
endmodule

// ==== pkg/itas_pkg.sv ====
// Purpose: shared constants for the ignition timing, alarm and aux sync block
// Assumes: 125 MHz clk, byte addresses on the register bus, one word per register
// Notes:   timing values are signed 16-bit angle units, speeds unsigned 16-bit
package itas_pkg;
	localparam int CLK_NS     = 8;
	localparam int US_NS      = 1000;
	localparam int US_CYC     = (US_NS + CLK_NS - 1) / CLK_NS;
	localparam int MS_US      = 1000;
	localparam int ASO_MAX_US = 300;
	localparam int N_ALARM    = 16;
	localparam int N_ASO      = 16;
	localparam int N_CURVE    = 8;
	localparam int N_AN       = 2;
	localparam int N_SRC      = 8;
	// register byte addresses
	localparam logic [8:0] A_CTRL   = 9'h000;
	localparam logic [8:0] A_BASE   = 9'h004;
	localparam logic [8:0] A_LIM    = 9'h008;
	localparam logic [8:0] A_STEP   = 9'h00c;
	localparam logic [8:0] A_AN     = 9'h010;
	localparam logic [8:0] A_CURVE  = 9'h020;
	localparam logic [8:0] A_ASO    = 9'h040;
	localparam logic [8:0] A_ALARM  = 9'h080;
	localparam logic [8:0] A_START  = 9'h100;
	localparam logic [8:0] A_EN_S   = 9'h104;
	localparam logic [8:0] A_EN_N   = 9'h108;
	localparam logic [8:0] A_ELIM   = 9'h10c;
	localparam logic [8:0] A_STAT   = 9'h110;
	localparam logic [8:0] A_ACK    = 9'h114;
	localparam logic [8:0] A_TIMING = 9'h118;
	// control register fields
	localparam int C_CURVE   = 0;
	localparam int C_AN      = 1;
	localparam int C_POT     = 3;
	localparam int C_GPO_NC  = 4;
	localparam int C_ASO_INV = 5;
	localparam int C_ASO_GT  = 6;
	localparam int C_NPTS    = 8;
	localparam int C_NCURV   = 12;
	// alarm word 1 fields
	localparam int AL_SRC    = 16;
	localparam int AL_BELOW  = 19;
	localparam int AL_SHUT   = 20;
	localparam int AL_PERM   = 21;
	localparam int AL_ROUTE  = 22;
	// status fields
	localparam int S_START   = 16;
	localparam int S_OPERR   = 17;
	localparam int S_ANERR   = 18;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] LIM_RST  = 32'h7fff_8000;
	localparam logic [31:0] STEP_RST = 32'h7fff_7fff;
	localparam logic [31:0] ZERO_RST = 32'h0000_0000;
	typedef enum logic [2:0] {
		PH_IDLE  = 3'b001,
		PH_START = 3'b010,
		PH_NORM  = 3'b100
	} itas_phase_e;
endpackage

// ==== verilog/itas_alarm.sv ====
// Purpose: one alarm channel: compare, delay, hysteresis, latch
// Assumes: tick_us is a one-cycle pulse every microsecond
// Notes:   the delay counts whole microseconds, so the trigger lags by up to one tick
`timescale 1ns/1ps
module itas_alarm (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        tick_us,
	input  wire logic [15:0] value,
	input  wire logic [15:0] thr,
	input  wire logic [15:0] hyst,
	input  wire logic [15:0] delay,
	input  wire logic        below,
	input  wire logic        ack,
	output logic             active,
	output logic             latched
);
	logic        cond;
	logic        clr;
	logic [15:0] cnt;

	assign cond = below ? (value < thr) : (value > thr);
	// clearing needs the value back past the threshold by the hysteresis
	assign clr = below ? ({1'b0, value} >= {1'b0, thr} + {1'b0, hyst}) :
		({1'b0, value} + {1'b0, hyst} <= {1'b0, thr});

	always_ff @(posedge clk) begin
		if (srst || !cond || active)
			cnt <= 16'h0;
		else if (tick_us && cnt != 16'hffff)
			cnt <= cnt + 16'h1;
	end

	always_ff @(posedge clk) begin
		if (srst)
			active <= 1'b0;
		else if (!active && cond && cnt > delay)
			active <= 1'b1;
		else if (active && clr)
			active <= 1'b0;
	end

	// set wins over acknowledge
	always_ff @(posedge clk) begin
		if (srst)
			latched <= 1'b0;
		else if (active)
			latched <= 1'b1;
		else if (ack)
			latched <= 1'b0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_delay_guard: assert property ($rose(active) |-> $past(cond) && $past(cnt) > $past(delay))
		else $error("alarm rose before its delay ran out");
	a_hyst_clear: assert property ($fell(active) |-> $past(clr))
		else $error("alarm cleared inside the hysteresis band");
	c_alarm_trip: cover property ($rose(active));
endmodule

// ==== testbench/itas_pickup_model.sv ====
// Purpose: pickup side stand-in: crank angle, angle steps, fire strobes, sync
// Assumes: one angle step every four clocks, 720 units per engine cycle
// Notes:   sync only after one full engine cycle, so early aux pulses must stay quiet
`timescale 1ns/1ps
module itas_pickup_model (
	input  wire logic        clk,
	input  wire logic        srst,
	output logic             sync_ok,
	output logic [15:0]      crank_angle,
	output logic             angle_step,
	output logic             fire_strobe
);
	logic [1:0] div;
	always_ff @(posedge clk) begin
		if (srst) begin
			div <= 2'h0;
			sync_ok <= 1'b0;
			crank_angle <= 16'h0000;
			angle_step <= 1'b0;
			fire_strobe <= 1'b0;
		end else begin
			div <= div + 2'h1;
			angle_step <= (div == 2'h3);
			fire_strobe <= (div == 2'h3) && (crank_angle[5:0] == 6'h3f);
			if (div == 2'h3)
				crank_angle <= (crank_angle == 16'h02cf) ? 16'h0000 : crank_angle + 16'h0001;
			if (div == 2'h3 && crank_angle == 16'h02cf)
				sync_ok <= 1'b1;
		end
	end
endmodule

// ==== testbench/ignition_timing_alarm_sync_out_bench.sv ====
// Purpose: self-checking bench for timing, alarms and aux sync output
// Assumes: pickup model drives angle, fire and sync inputs
// Notes:   firing held active, so timing-shifted aux gating goes unexercised
`timescale 1ns/1ps
module ignition_timing_alarm_sync_out_bench;
	logic         clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic         cyl_req_valid = 1'b0, firing_active = 1'b1;
	logic [8:0]   avs_address = 9'h000;
	logic [31:0]  avs_writedata = 32'h0, analog_in = 32'h0, avs_readdata, q;
	logic [3:0]   avs_byteenable = 4'hf;
	logic [15:0]  engine_speed = 16'h0, pot_offset = 16'h0, cyl_req = 16'h0, b, t;
	logic [15:0]  crank_angle, cyl_out, timing_target, timing_out, spark_dur;
	logic         start_phase;
	logic [127:0] mon_values = 128'h0;
	logic         avs_waitrequest, sync_ok, angle_step, fire_strobe;
	logic         general_output_one, aux_sync_output_one, ignition_off;
	int           bad_count = 0, checked = 0, n;
	itas_pickup_model pk (.clk, .srst, .sync_ok, .crank_angle, .angle_step, .fire_strobe);
	itas_top dut (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .sync_ok, .firing_active,
		.crank_angle, .angle_step, .fire_strobe, .engine_speed, .analog_in, .pot_offset,
		.mon_values, .cyl_req_valid, .cyl_req, .cyl_out, .timing_target, .timing_out,
		.spark_dur, .spark_int(), .spark_bdv(), .start_phase, .op_error(),
		.ignition_off, .general_output_one, .aux_sync_output_one);
	initial forever #4 clk = ~clk;
	// waitrequest and readdata are read at the rising edge, before the slave updates
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	function automatic logic [15:0] clamp(input logic signed [15:0] v, lo, hi);
		return (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction
	task automatic end_of_test;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h50c5));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		engine_speed <= 16'($urandom);
		analog_in <= $urandom;
		pot_offset <= 16'($urandom);
		chk(aux_sync_output_one, 1'b1); // idle level
		bus(0, 9'h008, 32'h0);
		chk(q, 32'h7fff_8000);
		bus(0, 9'h00c, 32'h0);
		chk(q, 32'h7fff_7fff);
		bus(0, 9'h1fc, 32'h0);
		chk(q, 32'h0);
		bus(1, 9'h008, 32'h0064_ff9c);
		for (int i = 0; i < 6; i++) begin
			b = (i == 0) ? 16'h8000 : (i == 1) ? 16'h0064 : 16'($urandom);
			bus(1, 9'h004, {16'h0, b});
			repeat (3) @(posedge clk);
			chk(timing_target, clamp(b, 16'hff9c, 16'h0064)); // clamp
		end
		bus(1, 9'h00c, 32'h0032_0004);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			cyl_req <= (i == 0) ? 16'h8000 : 16'($urandom);
			cyl_req_valid <= 1'b1;
			@(posedge clk);
			cyl_req_valid <= 1'b0;
			@(posedge clk);
			@(negedge clk);
			chk(cyl_out, clamp(cyl_req, 16'hffce, 16'h0032)); // clamp
		end
		bus(1, 9'h004, 32'h0000_0032); // base inside limits
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			while (fire_strobe !== 1'b1) @(negedge clk);
			t = timing_out;
			@(negedge clk);
			chk(timing_out, t + clamp(timing_target - t, 16'hfffc, 16'h0004)); // step
		end
		// slot 1 is not enabled, so the long test pulse never fires
		bus(1, 9'h044, 32'h012c_000a);
		bus(1, 9'h044, 32'h012d_0014);
		bus(0, 9'h044, 32'h0);
		chk(q, 32'h012c_000a); // length cap
		bus(1, 9'h040, 32'h0002_000a);
		n = 0;
		while (aux_sync_output_one !== 1'b0 && n < 9000) begin
			@(negedge clk);
			n++;
		end
		chk(crank_angle, 16'h000a); // edge at angle
		n = 0;
		while (aux_sync_output_one === 1'b0 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk(n >= 125 && n <= 375, 1'b1); // length in us
		bus(1, 9'h000, 32'h0000_0020);
		@(negedge clk);
		chk(aux_sync_output_one, 1'b0); // inverted idle
		bus(1, 9'h108, 32'h0010_0100);
		bus(1, 9'h10c, 32'h0000_0800);
		repeat (3) @(posedge clk);
		chk(start_phase, 1'b0); // no criteria, no start phase
		chk(spark_dur, 16'h0080); // limit cuts normal duration
		bus(1, 9'h080, 32'h000a_0064);
		bus(1, 9'h084, 32'h0050_0002);
		mon_values[15:0] <= 16'h00c8;
		repeat (100) @(posedge clk);
		mon_values[15:0] <= 16'h0000;
		@(negedge clk);
		chk(ignition_off, 1'b0); // short excursion ignored
		@(posedge clk);
		mon_values[15:0] <= 16'h00c8;
		repeat (1000) @(posedge clk);
		chk(ignition_off, 1'b1); // shutdown
		chk(general_output_one, 1'b1); // routed output
		mon_values[15:0] <= 16'h005f;
		repeat (20) @(posedge clk);
		chk(general_output_one, 1'b1); // inside hysteresis
		mon_values[15:0] <= 16'h0000;
		repeat (20) @(posedge clk);
		chk(general_output_one, 1'b0); // follows alarm
		end_of_test();
	end
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
endmodule
